// file: hgc_config_regs.sv
`timescale 1ns/1ps

// Overview of operation
// - Frame byte counter: low five bits bytes mod 32, top three bits blocks.
// - From 224 bytes the block field stays at 111, low field keeps counting.
// - Peripheral monitor receive register returns second-channel byte, resets to FF.
// - GCI: 64k uses bit 2 for B1/B2, bits 4-7 channel; 16k bits 4-7.
// - Multiplexed: bits 2-7 pick of 64 slots at 64k, bits 0-7 of 256.
// - Filter enable bits 0-6 each enable one SAPI or TEI value.
// - Filter bit 7 activates address filtering; all filter bits reset to zero.
// - SAPI x and y sit in upper six bits, two low bits zero.
// - TEI z and t sit in upper seven bits, lowest bit zero.
// - Three-slot bit makes each frame three GCI channels.
// - In GCI three-slot 16k mode the shared bit selects slave or master.
// - Subchannel enable uses 8/56k subchannel; shared bit picks which part.
// - Rate select: one means 64 kbit/s, zero means 16 kbit/s.
// - In GCI three-slot 16k mode contention bit enables D and C/I access.
// - Peripheral interface enable works only in three-slot mode.
// - Idle received, wake transmitted, pull-down enabled, loopback off: drive DOUT low.
// - Interface select: one GCI, zero multiplexed; separate mux enable bit.
// - Loopback routes transmitter to receiver and leaves DOUT undriven.
// - With address check, accept message only if first byte equals address.
// - Contention access address is the low three component address bits.
// - Double clock bit: clock twice data rate when one, equal when zero.
// - Output mode bit: tristate output when one, open drain when zero.
module hgc_config_regs
  import hgc_pkg::*;
(
  input  wire logic         CLK_SYS,
  input  wire logic         RST_B,
  input  wire hgc_bus_req_t BUS_REQ,
  output logic [7:0]        RDATA,
  input  wire logic         RX_FRAME_CLR,
  input  wire logic         RX_BYTE_STB,
  input  wire logic         RX_ADDR_STB,
  input  wire logic [5:0]   RX_SAPI,
  input  wire logic [6:0]   RX_TEI,
  output logic              ADDR_MATCH,
  input  wire logic         MON2_BYTE_STB,
  input  wire logic [7:0]   MON2_BYTE,
  input  wire logic         MON2_EOM,
  output logic              MON2_RX_NEW,
  input  wire logic [3:0]   CI_RX1,
  input  wire logic [3:0]   CI_TX1,
  input  wire logic         TX_DATA,
  input  wire logic         TX_ACTIVE,
  input  wire logic         DOUT_I,
  output logic              DOUT_O,
  output logic              DOUT_OE_B,
  output logic              RX_DATA,
  output logic [3:0]        SLOT_CHAN,
  output logic              SLOT_B2,
  output logic              SLOT_D_CHAN,
  output logic [7:0]        SLOT_INDEX,
  output logic [7:0]        MODE_STATUS,
  output logic [2:0]        CONTENTION_ADDR
);

  hgc_state_t st;
  hgc_state_t next_st;

  // GCI, three-slot, 16 kbit/s with mux active
  function automatic logic f_gci16_three_slot(input logic [7:0] m);
    f_gci16_three_slot = m[MODE_THREE_SLOT] & ~m[MODE_RATE_SEL]
                         & m[MODE_IF_SEL] & m[MODE_MUX_EN];
  endfunction : f_gci16_three_slot

  function automatic logic f_periph_active(input logic [7:0] m);
    f_periph_active = m[MODE_THREE_SLOT] & m[MODE_PERIPH_EN];
  endfunction : f_periph_active

  function automatic logic f_wake_drive(input logic [7:0] m, input logic [3:0] cir,
                                        input logic [3:0] cix);
    f_wake_drive = m[MODE_WAKE_PD] & (cir == IDLE_CODE) & (cix == WAKE_REQUEST_CODE);
  endfunction : f_wake_drive

  logic [3:0] comp_addr;
  logic       sapi_hit;
  logic       tei_hit;
  logic       wake;
  logic       mon_take;
  logic [7:0] rx_frame_byte_count_base;

  assign comp_addr = st.misc[MISC_ADDR_HI:MISC_ADDR_LO];

  always_comb
  begin
    next_st = st;
    next_st.mon_new = 1'b0;
    next_st.rdata = 8'h00;

    // Register writes
    if (BUS_REQ.wr)
    begin
      case (BUS_REQ.addr)
        OFS_SLOT_POSITION: next_st.slot = BUS_REQ.wdata;
        OFS_FILTER_EN:     next_st.filt = BUS_REQ.wdata;
        OFS_SAPI_X:        next_st.sapi_x = {BUS_REQ.wdata[7:2], 2'b00};
        OFS_SAPI_Y:        next_st.sapi_y = {BUS_REQ.wdata[7:2], 2'b00};
        OFS_TEI_Z:         next_st.tei_z = {BUS_REQ.wdata[7:1], 1'b0};
        OFS_TEI_T:         next_st.tei_t = {BUS_REQ.wdata[7:1], 1'b0};
        OFS_MODE_CONFIG:   next_st.mode = BUS_REQ.wdata;
        OFS_MISC_CONFIG:   next_st.misc = BUS_REQ.wdata;
        default:           next_st.slot = st.slot;
      endcase
    end

    // Register reads, data in the following cycle
    if (BUS_REQ.rd)
    begin
      case (BUS_REQ.addr)
        OFS_SLOT_POSITION: next_st.rdata = st.slot;
        OFS_FILTER_EN:     next_st.rdata = st.filt;
        OFS_SAPI_X:        next_st.rdata = st.sapi_x;
        OFS_SAPI_Y:        next_st.rdata = st.sapi_y;
        OFS_TEI_Z:         next_st.rdata = st.tei_z;
        OFS_TEI_T:         next_st.rdata = st.tei_t;
        OFS_MODE_CONFIG:   next_st.rdata = st.mode;
        OFS_MISC_CONFIG:   next_st.rdata = st.misc;
        OFS_PERIPH_MON_RX: next_st.rdata = st.mon_rx;
        OFS_RX_BYTE_COUNT: next_st.rdata = st.rx_frame_byte_count;
        default:           next_st.rdata = 8'h00;
      endcase
    end

    // Receive frame byte counter; a byte in the clear cycle counts as the first
    rx_frame_byte_count_base = RX_FRAME_CLR ? 8'h00 : st.rx_frame_byte_count;
    next_st.rx_frame_byte_count = rx_frame_byte_count_base;
    if (RX_BYTE_STB)
    begin
      next_st.rx_frame_byte_count[RX_FRAME_BYTE_COUNT_LOW_BITS-1:0] = rx_frame_byte_count_base[RX_FRAME_BYTE_COUNT_LOW_BITS-1:0] + 5'h01;
      if (rx_frame_byte_count_base[RX_FRAME_BYTE_COUNT_LOW_BITS-1:0] == RX_FRAME_BYTE_COUNT_LOW_MAX
          && rx_frame_byte_count_base[7:RX_FRAME_BYTE_COUNT_LOW_BITS] != RX_FRAME_BYTE_COUNT_BLK_MAX)
        next_st.rx_frame_byte_count[7:RX_FRAME_BYTE_COUNT_LOW_BITS] = rx_frame_byte_count_base[7:RX_FRAME_BYTE_COUNT_LOW_BITS] + 3'h1;
    end

    // Address filter over received SAPI and TEI
    sapi_hit = (st.filt[FLT_SAPI_0] && RX_SAPI == SAPI_FIXED_LOW)
             | (st.filt[FLT_SAPI_63] && RX_SAPI == SAPI_FIXED_HIGH)
             | (st.filt[FLT_SAPI_X] && RX_SAPI == st.sapi_x[7:2])
             | (st.filt[FLT_SAPI_Y] && RX_SAPI == st.sapi_y[7:2]);
    tei_hit  = (st.filt[FLT_TEI_127] && RX_TEI == TEI_FIXED_GROUP)
             | (st.filt[FLT_TEI_Z] && RX_TEI == st.tei_z[7:1])
             | (st.filt[FLT_TEI_T] && RX_TEI == st.tei_t[7:1]);
    if (RX_ADDR_STB)
      next_st.match = ~st.filt[FLT_ACTIVE] | sapi_hit | tei_hit;

    // Peripheral monitor channel reception
    mon_take = 1'b0;
    if (MON2_BYTE_STB && f_periph_active(st.mode))
    begin
      next_st.mon_first = 1'b0;
      if (st.mon_first)
      begin
        next_st.mon_reject = st.misc[MISC_ADDR_CHK]
                             && (MON2_BYTE != {4'h0, comp_addr});
        mon_take = ~next_st.mon_reject;
      end
      else
        mon_take = ~st.mon_reject;
    end
    if (mon_take)
    begin
      next_st.mon_rx = MON2_BYTE;
      next_st.mon_new = 1'b1;
    end
    if (MON2_EOM)
    begin
      next_st.mon_first = 1'b1;
      next_st.mon_reject = 1'b0;
    end

    // Slot position decode
    next_st.slot_d_chan = st.mode[MODE_IF_SEL] & ~st.mode[MODE_RATE_SEL];
    if (st.mode[MODE_IF_SEL])
    begin
      next_st.slot_chan = st.slot[7:4];
      next_st.slot_b2 = st.mode[MODE_RATE_SEL] & st.slot[2];
      next_st.slot_index = 8'h00;
    end
    else
    begin
      next_st.slot_chan = 4'h0;
      next_st.slot_b2 = 1'b0;
      next_st.slot_index = st.mode[MODE_RATE_SEL] ? {2'b00, st.slot[7:2]} : st.slot;
    end

    // Serial pin: input qualifier, loopback and output drive
    next_st.din_sync = {st.din_sync[1:0], DOUT_I};
    if (st.din_sync[1] == st.din_sync[2])
      next_st.din = st.din_sync[2];
    wake = f_wake_drive(st.mode, CI_RX1, CI_TX1);
    next_st.rx_data = st.misc[MISC_LOOPBACK] ? TX_DATA : st.din;
    next_st.dout_o = 1'b0;
    if (st.misc[MISC_LOOPBACK])
      next_st.dout_oe_b = 1'b1;
    else if (wake)
      next_st.dout_oe_b = 1'b0;
    else if (!TX_ACTIVE)
      next_st.dout_oe_b = 1'b1;
    else if (st.misc[MISC_TRISTATE])
    begin
      next_st.dout_o = TX_DATA;
      next_st.dout_oe_b = 1'b0;
    end
    else
      next_st.dout_oe_b = TX_DATA;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      st <= '0;
      st.mon_rx <= RST_MON_RX;
      st.slot <= RST_CFG;
      st.filt <= RST_CFG;
      st.mode <= RST_CFG;
      st.misc <= RST_CFG;
      st.mon_first <= 1'b1;
      st.match <= 1'b1;
      st.dout_oe_b <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign RDATA = st.rdata;
  assign ADDR_MATCH = st.match;
  assign MON2_RX_NEW = st.mon_new;
  assign DOUT_O = st.dout_o;
  assign DOUT_OE_B = st.dout_oe_b;
  assign RX_DATA = st.rx_data;
  assign SLOT_CHAN = st.slot_chan;
  assign SLOT_B2 = st.slot_b2;
  assign SLOT_D_CHAN = st.slot_d_chan;
  assign SLOT_INDEX = st.slot_index;
  // Decoded mode flags, each held in the registered mode and misc bits
  assign MODE_STATUS = {st.mode[MODE_THREE_SLOT],
                        st.mode[MODE_ROLE_HALF],
                        st.mode[MODE_RATE_SEL],
                        st.mode[MODE_CONT_SUB],
                        st.mode[MODE_PERIPH_EN],
                        st.mode[MODE_IF_SEL],
                        st.mode[MODE_MUX_EN],
                        st.misc[MISC_DBL_CLOCK]};
  assign CONTENTION_ADDR = st.misc[MISC_ADDR_LO+2:MISC_ADDR_LO];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence s_wake_cond;
    st.mode[MODE_WAKE_PD] && CI_RX1 == IDLE_CODE && CI_TX1 == WAKE_REQUEST_CODE;
  endsequence

  sequence s_no_loop;
    !st.misc[MISC_LOOPBACK];
  endsequence

  a_wake_drives_low: assert property (s_wake_cond and s_no_loop |=> !DOUT_OE_B && !DOUT_O)
    else $error("wake request did not pull DOUT low");

  a_loop_no_drive: assert property (st.misc[MISC_LOOPBACK] |=> DOUT_OE_B && RX_DATA == $past(TX_DATA))
    else $error("loopback still drives DOUT or misroutes data");

  a_block_saturate: assert property (RX_BYTE_STB && !RX_FRAME_CLR && st.rx_frame_byte_count[7:5] == RX_FRAME_BYTE_COUNT_BLK_MAX
                                     |=> st.rx_frame_byte_count[7:5] == RX_FRAME_BYTE_COUNT_BLK_MAX)
    else $error("block count left 111");

  a_block_carry: assert property (RX_BYTE_STB && !RX_FRAME_CLR && st.rx_frame_byte_count == 8'h1F
                                  |=> st.rx_frame_byte_count == 8'h20)
    else $error("byte counter did not carry into block field");

  a_sapi_low_zero: assert property (st.sapi_x[1:0] == 2'b00 && st.sapi_y[1:0] == 2'b00)
    else $error("SAPI low bits not zero");

  a_tei_low_zero: assert property (st.tei_z[0] == 1'b0 && st.tei_t[0] == 1'b0)
    else $error("TEI low bit not zero");

  a_read_latency: assert property (BUS_REQ.rd && BUS_REQ.addr == OFS_MODE_CONFIG
                                   && !$past(BUS_REQ.wr) |=> RDATA == $past(st.mode))
    else $error("read data not returned the cycle after the strobe");

  a_periph_gated: assert property (!f_periph_active(st.mode) |=> !MON2_RX_NEW)
    else $error("monitor byte captured with peripheral interface off");

  a_addr_reject: assert property (MON2_BYTE_STB && st.mon_first && !MON2_EOM
                                  && f_periph_active(st.mode) && st.misc[MISC_ADDR_CHK]
                                  && MON2_BYTE != {4'h0, comp_addr}
                                  |=> !MON2_RX_NEW ##1 st.mon_reject)
    else $error("foreign peripheral message accepted");

  a_filter_off_pass: assert property (RX_ADDR_STB && !st.filt[FLT_ACTIVE] |=> ADDR_MATCH)
    else $error("frame rejected with filter inactive");

endmodule : hgc_config_regs

// file: hgc_pkg.sv
package hgc_pkg;

  // Register indices on the 4-bit local address
  localparam logic [3:0] OFS_SLOT_POSITION = 4'h0;
  localparam logic [3:0] OFS_FILTER_EN     = 4'h1;
  localparam logic [3:0] OFS_SAPI_X        = 4'h2;
  localparam logic [3:0] OFS_SAPI_Y        = 4'h3;
  localparam logic [3:0] OFS_TEI_Z         = 4'h4;
  localparam logic [3:0] OFS_TEI_T         = 4'h5;
  localparam logic [3:0] OFS_MODE_CONFIG   = 4'h6;
  localparam logic [3:0] OFS_MISC_CONFIG   = 4'h7;
  localparam logic [3:0] OFS_PERIPH_MON_RX = 4'h8;
  localparam logic [3:0] OFS_RX_BYTE_COUNT = 4'h9;

  // Reset values
  localparam logic [7:0] RST_CFG    = 8'h00;
  localparam logic [7:0] RST_MON_RX = 8'hFF;

  // mode_config fields
  localparam int MODE_THREE_SLOT = 7;
  localparam int MODE_ROLE_HALF  = 6;
  localparam int MODE_RATE_SEL   = 5;
  localparam int MODE_CONT_SUB   = 4;
  localparam int MODE_PERIPH_EN  = 3;
  localparam int MODE_WAKE_PD    = 2;
  localparam int MODE_IF_SEL     = 1;
  localparam int MODE_MUX_EN     = 0;

  // misc_config fields
  localparam int MISC_LOOPBACK  = 7;
  localparam int MISC_ADDR_CHK  = 6;
  localparam int MISC_ADDR_HI   = 5;
  localparam int MISC_ADDR_LO   = 2;
  localparam int MISC_DBL_CLOCK = 1;
  localparam int MISC_TRISTATE  = 0;

  // addr_filter_enables fields
  localparam int FLT_SAPI_0   = 0;
  localparam int FLT_SAPI_63  = 1;
  localparam int FLT_SAPI_X   = 2;
  localparam int FLT_SAPI_Y   = 3;
  localparam int FLT_TEI_127  = 4;
  localparam int FLT_TEI_Z    = 5;
  localparam int FLT_TEI_T    = 6;
  localparam int FLT_ACTIVE   = 7;

  localparam logic [5:0] SAPI_FIXED_LOW  = 6'h00;
  localparam logic [5:0] SAPI_FIXED_HIGH = 6'h3F;
  localparam logic [6:0] TEI_FIXED_GROUP = 7'h7F;

  // Command/indicate codes
  localparam logic [3:0] IDLE_CODE         = 4'hF;
  localparam logic [3:0] WAKE_REQUEST_CODE = 4'h0;

  // Receive frame byte counter layout
  localparam int         RX_FRAME_BYTE_COUNT_LOW_BITS = 5;
  localparam logic [4:0] RX_FRAME_BYTE_COUNT_LOW_MAX  = 5'h1F;
  localparam logic [2:0] RX_FRAME_BYTE_COUNT_BLK_MAX  = 3'h7;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } hgc_bus_req_t;

  typedef struct packed {
    logic [7:0] slot;
    logic [7:0] filt;
    logic [7:0] sapi_x;
    logic [7:0] sapi_y;
    logic [7:0] tei_z;
    logic [7:0] tei_t;
    logic [7:0] mode;
    logic [7:0] misc;
    logic [7:0] mon_rx;
    logic [7:0] rx_frame_byte_count;
    logic [7:0] rdata;
    logic [2:0] din_sync;
    logic       din;
    logic       mon_first;
    logic       mon_reject;
    logic       mon_new;
    logic       match;
    logic       dout_o;
    logic       dout_oe_b;
    logic       rx_data;
    logic [3:0] slot_chan;
    logic       slot_b2;
    logic       slot_d_chan;
    logic [7:0] slot_index;
  } hgc_state_t;

endpackage : hgc_pkg

// file: hgc_line_model.sv
`timescale 1ns/1ps

module hgc_line_model
(
  input  wire logic       clk,
  input  wire logic       dout_o,
  input  wire logic       dout_oe_b,
  output logic            dout_i,
  output logic [3:0]      ci_rx,
  output logic            mon_stb,
  output logic [7:0]      mon_byte,
  output logic            mon_eom
);
  // Pulled-up line: a released pin reads high
  assign dout_i = (dout_oe_b === 1'b0) ? dout_o : 1'b1;
  initial
  begin
    ci_rx    = 4'hF;
    mon_stb  = 1'b0;
    mon_byte = 8'h00;
    mon_eom  = 1'b0;
  end
  task automatic set_ci(input logic [3:0] c);
    ci_rx <= c;
    @(posedge clk);
  endtask : set_ci
  // One monitor byte, or an end-of-message mark alone
  task automatic send_mon(input logic [7:0] b, input logic eom);
    mon_stb  <= ~eom;
    mon_byte <= b;
    mon_eom  <= eom;
    @(posedge clk);
    mon_stb  <= 1'b0;
    mon_byte <= ~b;
    mon_eom  <= 1'b0;
    @(posedge clk);
  endtask : send_mon
endmodule : hgc_line_model

// file: testbench.sv
`timescale 1ns/1ps

module testbench
  import hgc_pkg::*;
;
  logic         CLK_SYS, RST_B, clr, bstb, astb, match, mstb, meom, mnew;
  logic         tx_data, tx_act, dout_i, dout_o, dout_oe_b, rx_data, b2, dch;
  logic [3:0]   ci_rx, ci_tx, chan;
  logic [5:0]   sapi;
  logic [6:0]   tei;
  logic [7:0]   rdata, mbyte, sidx, mstat;
  logic [2:0]   caddr;
  hgc_bus_req_t req;
  int           num_errors, check_count, new_cnt, base;
  int           lens[7] = '{1, 31, 32, 33, 223, 224, 257};
  logic [5:0]   hs[7] = '{6'h00, 6'h3F, 6'h05, 6'h08, 6'h01, 6'h01, 6'h01};
  logic [6:0]   ht[7] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h7F, 7'h42, 7'h10};

  hgc_config_regs i_hgc_config_regs
  (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .BUS_REQ(req), .RDATA(rdata),
    .RX_FRAME_CLR(clr), .RX_BYTE_STB(bstb), .RX_ADDR_STB(astb),
    .RX_SAPI(sapi), .RX_TEI(tei), .ADDR_MATCH(match),
    .MON2_BYTE_STB(mstb), .MON2_BYTE(mbyte), .MON2_EOM(meom), .MON2_RX_NEW(mnew),
    .CI_RX1(ci_rx), .CI_TX1(ci_tx), .TX_DATA(tx_data), .TX_ACTIVE(tx_act),
    .DOUT_I(dout_i), .DOUT_O(dout_o), .DOUT_OE_B(dout_oe_b), .RX_DATA(rx_data),
    .SLOT_CHAN(chan), .SLOT_B2(b2), .SLOT_D_CHAN(dch), .SLOT_INDEX(sidx),
    .MODE_STATUS(mstat), .CONTENTION_ADDR(caddr)
  );

  hgc_line_model i_hgc_line_model
  (
    .clk(CLK_SYS), .dout_o(dout_o), .dout_oe_b(dout_oe_b), .dout_i(dout_i),
    .ci_rx(ci_rx), .mon_stb(mstb), .mon_byte(mbyte), .mon_eom(meom)
  );

  always #12.5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (mnew === 1'b1) new_cnt++;

  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic reset;
    RST_B <= 1'b0;
    repeat (10) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    @(posedge CLK_SYS);
  endtask : reset

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge CLK_SYS);
    req <= '0;
    @(posedge CLK_SYS);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge CLK_SYS);
    req <= '0;
    #1 check($sformatf("reg %0h", a), e, rdata);
    @(posedge CLK_SYS);
  endtask : rdc

  task automatic frame(input int n);
    clr  <= 1'b1;
    bstb <= 1'b1;
    @(posedge CLK_SYS);
    clr <= 1'b0;
    repeat (n - 1) @(posedge CLK_SYS);
    bstb <= 1'b0;
    @(posedge CLK_SYS);
  endtask : frame

  task automatic flt(input logic [5:0] s, input logic [6:0] t, input logic e);
    sapi <= s;
    tei  <= t;
    astb <= 1'b1;
    @(posedge CLK_SYS);
    astb <= 1'b0;
    #1 check("addr_match", 8'(e), 8'(match));
    @(posedge CLK_SYS);
  endtask : flt

  task automatic sl(input logic [7:0] m, input logic [7:0] s);
    wr(OFS_MODE_CONFIG, m);
    wr(OFS_SLOT_POSITION, s);
    @(posedge CLK_SYS);
  endtask : sl

  task automatic pin(input logic [7:0] m, input logic td, input logic eoe, input logic eo);
    wr(OFS_MISC_CONFIG, m);
    tx_data <= td;
    repeat (8) @(posedge CLK_SYS);
    #1 check("dout_oe_b", 8'(eoe), 8'(dout_oe_b));
    if (!eoe)
      check("dout_o", 8'(eo), 8'(dout_o));
    check("rx_data", 8'(m[7] ? td : (eoe | eo)), 8'(rx_data));
  endtask : pin

  initial
  begin
    repeat (100000) @(posedge CLK_SYS);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    CLK_SYS = 1'b0;
    RST_B = 1'b0;
    req = '0;
    {clr, bstb, astb, tx_data, tx_act, sapi, tei} = '0;
    ci_tx = 4'hF;
    reset();
    for (int a = 0; a < 8; a++)
      rdc(4'(a), RST_CFG);
    rdc(OFS_PERIPH_MON_RX, RST_MON_RX);
    rdc(OFS_RX_BYTE_COUNT, 8'h00);
    rdc(4'hC, 8'h00);
    #1 check("rdata_idle", 8'h00, rdata);
    @(posedge CLK_SYS);
    check("dout_oe_b", 8'h01, 8'(dout_oe_b));
    for (int a = 0; a < 8; a++)
      wr(4'(a), 8'hFF);
    for (int a = 0; a < 8; a++)
      rdc(4'(a), (a inside {2, 3}) ? 8'hFC : (a inside {4, 5}) ? 8'hFE : 8'hFF);
    wr(OFS_PERIPH_MON_RX, 8'h00);
    wr(OFS_RX_BYTE_COUNT, 8'hAA);
    rdc(OFS_PERIPH_MON_RX, 8'hFF);
    rdc(OFS_RX_BYTE_COUNT, 8'h00);
    reset();
    foreach (lens[i])
    begin
      frame(lens[i]);
      rdc(OFS_RX_BYTE_COUNT, {(lens[i] > 223) ? 3'h7 : 3'(lens[i] / 32), 5'(lens[i] % 32)});
    end
    wr(OFS_SAPI_X, 8'h14);
    wr(OFS_SAPI_Y, 8'h20);
    wr(OFS_TEI_Z, 8'h84);
    wr(OFS_TEI_T, 8'h20);
    for (int k = 0; k < 7; k++)
    begin
      wr(OFS_FILTER_EN, 8'h80 | (8'h01 << k));
      flt(hs[k], ht[k], 1'b1);
      flt(6'h01, 7'h01, 1'b0);
    end
    wr(OFS_FILTER_EN, 8'h7F);
    flt(6'h01, 7'h01, 1'b1);
    sl(8'h22, 8'hA4);
    check("slot_chan", 8'h0A, 8'(chan));
    check("slot_b2", 8'h01, 8'(b2));
    check("slot_d_chan", 8'h00, 8'(dch));
    sl(8'h22, 8'h5B);
    check("slot_b2", 8'h00, 8'(b2));
    sl(8'h02, 8'h3C);
    check("slot_chan", 8'h03, 8'(chan));
    check("slot_d_chan", 8'h01, 8'(dch));
    sl(8'h20, 8'hFC);
    check("slot_index", 8'h3F, sidx);
    sl(8'h00, 8'hA7);
    check("slot_index", 8'hA7, sidx);
    wr(OFS_MODE_CONFIG, 8'hA5);
    wr(OFS_MISC_CONFIG, 8'h02);
    check("mode_status", 8'hA3, mstat);
    wr(OFS_MODE_CONFIG, 8'h5A);
    wr(OFS_MISC_CONFIG, 8'h14);
    check("mode_status", 8'h5C, mstat);
    check("contention_addr", 8'h05, 8'(caddr));
    reset();
    wr(OFS_MODE_CONFIG, 8'h04);
    ci_tx <= 4'h0;
    repeat (3) @(posedge CLK_SYS);
    check("dout_oe_b", 8'h00, 8'(dout_oe_b));
    check("dout_line", 8'h00, 8'(dout_i));
    i_hgc_line_model.set_ci(4'h3);
    repeat (3) @(posedge CLK_SYS);
    check("dout_oe_b", 8'h01, 8'(dout_oe_b));
    i_hgc_line_model.set_ci(4'hF);
    ci_tx <= 4'hF;
    tx_act <= 1'b1;
    pin(8'h00, 1'b0, 1'b0, 1'b0);
    pin(8'h00, 1'b1, 1'b1, 1'b1);
    pin(8'h01, 1'b1, 1'b0, 1'b1);
    pin(8'h01, 1'b0, 1'b0, 1'b0);
    pin(8'h80, 1'b0, 1'b1, 1'b0);
    pin(8'h80, 1'b1, 1'b1, 1'b1);
    reset();
    base = new_cnt;
    i_hgc_line_model.send_mon(8'h12, 1'b0);
    rdc(OFS_PERIPH_MON_RX, 8'hFF);
    wr(OFS_MODE_CONFIG, 8'h88);
    wr(OFS_MISC_CONFIG, 8'h54);
    i_hgc_line_model.send_mon(8'h00, 1'b1);
    i_hgc_line_model.send_mon(8'h05, 1'b0);
    rdc(OFS_PERIPH_MON_RX, 8'h05);
    i_hgc_line_model.send_mon(8'h33, 1'b0);
    i_hgc_line_model.send_mon(8'h00, 1'b1);
    i_hgc_line_model.send_mon(8'h07, 1'b0);
    i_hgc_line_model.send_mon(8'h44, 1'b0);
    rdc(OFS_PERIPH_MON_RX, 8'h33);
    wr(OFS_MISC_CONFIG, 8'h14);
    i_hgc_line_model.send_mon(8'h00, 1'b1);
    i_hgc_line_model.send_mon(8'h07, 1'b0);
    rdc(OFS_PERIPH_MON_RX, 8'h07);
    check("mon_rx_new", 8'h03, 8'(new_cnt - base));
    print_verdict();
  end
endmodule : testbench
